//--- motion_pkg.sv
// constants shared by the offset trim and activity detection block
package motion_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] X_OFFSET_TRIM_ADDR = 8'h20;
    localparam logic [7:0] Y_OFFSET_TRIM_ADDR = 8'h21;
    localparam logic [7:0] Z_OFFSET_TRIM_ADDR = 8'h22;
    localparam logic [7:0] X_MOTION_LIMIT_HIGH_ADDR = 8'h23;
    localparam logic [7:0] X_MOTION_LIMIT_LOW_ADDR = 8'h24;
    localparam logic [7:0] Y_MOTION_LIMIT_HIGH_ADDR = 8'h25;
    localparam logic [7:0] Y_MOTION_LIMIT_LOW_ADDR = 8'h26;
    localparam logic [7:0] Z_MOTION_LIMIT_HIGH_ADDR = 8'h27;
    localparam logic [7:0] Z_MOTION_LIMIT_LOW_ADDR = 8'h28;
    localparam logic [7:0] MOTION_PERSIST_TIME_ADDR = 8'h29;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int TRIM_WIDTH = 4;
    localparam int LIMIT_WIDTH = 11;
    localparam int SAMPLE_WIDTH = 12;
    localparam int LIMIT_LOW_LSB = 5;
    localparam int REF_SELECT_BIT = 1;
    localparam int PARTICIPATE_BIT = 0;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int UNIT_FAST_US = 3300;
    localparam int UNIT_SLOW_US = 6600;
    localparam int UNIT_FAST_CYCLES = UNIT_FAST_US * (CLK_HZ / 1_000_000);
    localparam int UNIT_SLOW_CYCLES = UNIT_SLOW_US * (CLK_HZ / 1_000_000);
    localparam int RATE_WIDTH = 3;
    localparam logic [2:0] RATE_CODE_FAST = 3'h4;

    typedef enum logic [1:0] {
        PERSIST_IDLE = 2'b00,
        PERSIST_COUNT = 2'b01,
        PERSIST_ACTIVE = 2'b10
    } persist_state_t;

endpackage : motion_pkg

//--- axis_trim_compare.sv
// one axis: offset trim, optional reference subtraction, limit compare
`timescale 1ns/100ps
`default_nettype none
module axis_trim_compare
    import motion_pkg::*;
#(
    parameter int SW = SAMPLE_WIDTH,
    parameter int LW = LIMIT_WIDTH
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic sample_valid_in,
    input wire logic [SW-1:0] sample_in,
    input wire logic [TRIM_WIDTH-1:0] trim_in,
    input wire logic [LW-1:0] limit_in,
    input wire logic participate_in,
    input wire logic ref_mode_in,
    input wire logic ref_capture_in,
    output logic [SW-1:0] trimmed_out,
    output logic above_out
);

    logic signed [SW:0] sum_w;
    logic [SW-1:0] trimmed_d;
    logic [SW-1:0] trimmed_q;
    logic [SW-1:0] ref_q;
    logic [SW-1:0] base_w;
    logic signed [SW:0] diff_w;
    logic [SW:0] mag_w;
    logic above_d;
    logic above_q;

    // ------------------------------------------------------------------
    // trim added at the sample lsb, saturating
    // ------------------------------------------------------------------
    assign sum_w = $signed({sample_in[SW-1], sample_in})
        + $signed({{(SW-TRIM_WIDTH+1){trim_in[TRIM_WIDTH-1]}}, trim_in});
    // clamp instead of wrap so a large trim never flips the sign
    assign trimmed_d = (sum_w[SW] != sum_w[SW-1])
        ? {sum_w[SW], {(SW-1){~sum_w[SW]}}} : sum_w[SW-1:0];

    // ------------------------------------------------------------------
    // magnitude against limit
    // ------------------------------------------------------------------
    // the sample that sets the baseline is measured against itself
    assign base_w = ref_capture_in ? trimmed_d : ref_q;
    assign diff_w = ref_mode_in
        ? $signed({trimmed_d[SW-1], trimmed_d})
          - $signed({base_w[SW-1], base_w})
        : $signed({trimmed_d[SW-1], trimmed_d});
    assign mag_w = diff_w[SW] ? SW'(0) - diff_w : diff_w;
    assign above_d = participate_in
        && (mag_w > {{(SW+1-LW){1'b0}}, limit_in});

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            trimmed_q <= '0;
            ref_q <= '0;
            above_q <= 1'b0;
        end else if (ce_in && sample_valid_in) begin
            trimmed_q <= trimmed_d;
            above_q <= above_d;
            if (ref_capture_in) begin
                ref_q <= trimmed_d;
            end
        end
    end

    assign trimmed_out = trimmed_q;
    assign above_out = above_q;

endmodule : axis_trim_compare
`default_nettype wire

//--- persist_tick.sv
// timer unit generator, period chosen by sample rate
`timescale 1ns/100ps
`default_nettype none
module persist_tick
    import motion_pkg::*;
#(
    parameter int FAST_CYCLES = UNIT_FAST_CYCLES,
    parameter int SLOW_CYCLES = UNIT_SLOW_CYCLES,
    parameter int CW = 18
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic restart_in,
    input wire logic fast_in,
    output logic tick_out
);

    logic [CW-1:0] count_q;
    logic [CW-1:0] last_w;
    logic wrap_w;

    assign last_w = fast_in ? CW'(FAST_CYCLES - 1)
                            : CW'(SLOW_CYCLES - 1);
    assign wrap_w = (count_q >= last_w);

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            count_q <= '0;
        end else if (ce_in) begin
            if (restart_in || wrap_w) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + CW'(1);
            end
        end
    end

    assign tick_out = ce_in && !restart_in && wrap_w;

endmodule : persist_tick
`default_nettype wire

//--- accel_offset_activity_detect.sv
// per-axis offset trim and activity detection with persistence timer
`timescale 1ns/100ps
`default_nettype none
// Operation
// - each axis holds a signed 4-bit trim in its low nibble, added to the data; upper nibble reads zero.
// - each axis limit is an 11-bit unsigned code at 100 mg per code.
// - activity compares the magnitude of each 12-bit signed sample with its limit.
// - the limit is high register bits 10..3 joined with low register bits 7..5 as bits 2..0.
// - the x low limit register bit 1 selects referenced processing when 1, absolute when 0.
// - an axis takes part only when bit 0 of its low limit register is 1.
// - with the timer in use only sustained motion declares activity.
// - motion must stay above the limit for the 8-bit persist count of timer units.
// - the timer unit is 3.3 ms at the 6400 Hz rate and 6.6 ms at 3200 Hz or lower.
// - samples are left-justified 12-bit two's complement values.
module accel_offset_activity_detect
    import motion_pkg::*;
#(
    parameter int FAST_CYCLES = UNIT_FAST_CYCLES,
    parameter int SLOW_CYCLES = UNIT_SLOW_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_write_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [RATE_WIDTH-1:0] output_sample_rate_in,
    input wire logic sample_valid_in,
    input wire logic [SAMPLE_WIDTH-1:0] x_sample_in,
    input wire logic [SAMPLE_WIDTH-1:0] y_sample_in,
    input wire logic [SAMPLE_WIDTH-1:0] z_sample_in,
    output logic [SAMPLE_WIDTH-1:0] x_trimmed_out,
    output logic [SAMPLE_WIDTH-1:0] y_trimmed_out,
    output logic [SAMPLE_WIDTH-1:0] z_trimmed_out,
    output logic trimmed_valid_out,
    output logic activity_event_out,
    output logic activity_active_out
);

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [TRIM_WIDTH-1:0] trim_q [3];
    logic [7:0] limit_high_q [3];
    logic [2:0] limit_low_q [3];
    logic participate_q [3];
    logic motion_reference_select_q;
    logic [7:0] motion_persist_count_q;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;

    logic [LIMIT_WIDTH-1:0] limit_w [3];
    logic wr_trim_w [3];
    logic wr_high_w [3];
    logic wr_low_w [3];
    logic wr_time_w;

    localparam logic [7:0] TRIM_ADDR [3] = '{X_OFFSET_TRIM_ADDR,
        Y_OFFSET_TRIM_ADDR, Z_OFFSET_TRIM_ADDR};
    localparam logic [7:0] HIGH_ADDR [3] = '{X_MOTION_LIMIT_HIGH_ADDR,
        Y_MOTION_LIMIT_HIGH_ADDR, Z_MOTION_LIMIT_HIGH_ADDR};
    localparam logic [7:0] LOW_ADDR [3] = '{X_MOTION_LIMIT_LOW_ADDR,
        Y_MOTION_LIMIT_LOW_ADDR, Z_MOTION_LIMIT_LOW_ADDR};

    assign wr_time_w = reg_write_in && (reg_addr_in == MOTION_PERSIST_TIME_ADDR);

    for (genvar a = 0; a < 3; a++) begin : g_dec
        assign wr_trim_w[a] = reg_write_in && (reg_addr_in == TRIM_ADDR[a]);
        assign wr_high_w[a] = reg_write_in && (reg_addr_in == HIGH_ADDR[a]);
        assign wr_low_w[a] = reg_write_in && (reg_addr_in == LOW_ADDR[a]);
        assign limit_w[a] = {limit_high_q[a], limit_low_q[a]};

        always_ff @(posedge clk_sys_in) begin
            if (reset_in) begin
                trim_q[a] <= REG_RESET[TRIM_WIDTH-1:0];
                limit_high_q[a] <= REG_RESET;
                limit_low_q[a] <= REG_RESET[2:0];
                participate_q[a] <= 1'b0;
            end else if (ce_in) begin
                if (wr_trim_w[a]) begin
                    trim_q[a] <= reg_wdata_in[TRIM_WIDTH-1:0];
                end
                if (wr_high_w[a]) begin
                    limit_high_q[a] <= reg_wdata_in;
                end
                if (wr_low_w[a]) begin
                    limit_low_q[a] <= reg_wdata_in[7:LIMIT_LOW_LSB];
                    participate_q[a] <= reg_wdata_in[PARTICIPATE_BIT];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            motion_reference_select_q <= 1'b0;
            motion_persist_count_q <= REG_RESET;
        end else if (ce_in) begin
            if (wr_low_w[0]) begin
                motion_reference_select_q <= reg_wdata_in[REF_SELECT_BIT];
            end
            if (wr_time_w) begin
                motion_persist_count_q <= reg_wdata_in;
            end
        end
    end

    // ------------------------------------------------------------------
    // read mux; reserved bits and unmapped offsets read zero
    // ------------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        case (reg_addr_in)
            X_OFFSET_TRIM_ADDR: rdata_d = {4'h0, trim_q[0]};
            Y_OFFSET_TRIM_ADDR: rdata_d = {4'h0, trim_q[1]};
            Z_OFFSET_TRIM_ADDR: rdata_d = {4'h0, trim_q[2]};
            X_MOTION_LIMIT_HIGH_ADDR: rdata_d = limit_high_q[0];
            Y_MOTION_LIMIT_HIGH_ADDR: rdata_d = limit_high_q[1];
            Z_MOTION_LIMIT_HIGH_ADDR: rdata_d = limit_high_q[2];
            X_MOTION_LIMIT_LOW_ADDR: rdata_d = {limit_low_q[0], 3'h0,
                motion_reference_select_q, participate_q[0]};
            Y_MOTION_LIMIT_LOW_ADDR: rdata_d = {limit_low_q[1], 4'h0,
                participate_q[1]};
            Z_MOTION_LIMIT_LOW_ADDR: rdata_d = {limit_low_q[2], 4'h0,
                participate_q[2]};
            MOTION_PERSIST_TIME_ADDR: rdata_d = motion_persist_count_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            rdata_q <= 8'h00;
        end else if (ce_in && reg_read_in) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;

    // ------------------------------------------------------------------
    // axis datapaths
    // ------------------------------------------------------------------
    logic [SAMPLE_WIDTH-1:0] sample_w [3];
    logic [SAMPLE_WIDTH-1:0] trimmed_w [3];
    logic above_w [3];
    logic ref_capture_w;
    logic ref_taken_q;
    logic valid_q;

    assign sample_w[0] = x_sample_in;
    assign sample_w[1] = y_sample_in;
    assign sample_w[2] = z_sample_in;

    for (genvar a = 0; a < 3; a++) begin : g_axis
        axis_trim_compare u_axis (
            .clk_sys_in(clk_sys_in),
            .reset_in(reset_in),
            .ce_in(ce_in),
            .sample_valid_in(sample_valid_in),
            .sample_in(sample_w[a]),
            .trim_in(trim_q[a]),
            .limit_in(limit_w[a]),
            .participate_in(participate_q[a]),
            .ref_mode_in(motion_reference_select_q),
            .ref_capture_in(ref_capture_w),
            .trimmed_out(trimmed_w[a]),
            .above_out(above_w[a])
        );
    end

    assign x_trimmed_out = trimmed_w[0];
    assign y_trimmed_out = trimmed_w[1];
    assign z_trimmed_out = trimmed_w[2];

    // ------------------------------------------------------------------
    // persistence timer
    // ------------------------------------------------------------------
    persist_state_t state_q;
    persist_state_t state_d;
    logic [7:0] units_q;
    logic [7:0] units_d;
    logic any_above_w;
    logic fast_w;
    logic tick_w;
    logic restart_w;
    logic event_d;
    logic event_q;

    // reference is retaken on an event declared in a sample cycle, and on the
    // first sample after referenced mode is chosen; that request is held, as a
    // one-cycle strobe would miss it, since samples arrive far apart
    assign ref_capture_w = event_d
        || (motion_reference_select_q && !ref_taken_q);
    assign any_above_w = above_w[0] || above_w[1] || above_w[2];
    assign fast_w = (output_sample_rate_in == RATE_CODE_FAST);
    assign restart_w = (state_q != PERSIST_COUNT);

    persist_tick #(
        .FAST_CYCLES(FAST_CYCLES),
        .SLOW_CYCLES(SLOW_CYCLES)
    ) u_tick (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .restart_in(restart_w),
        .fast_in(fast_w),
        .tick_out(tick_w)
    );

    always_comb begin
        state_d = state_q;
        units_d = units_q;
        event_d = 1'b0;
        case (state_q)
            PERSIST_IDLE: begin
                units_d = 8'h00;
                if (any_above_w) begin
                    // zero count declares on the first sample above
                    if (motion_persist_count_q == 8'h00) begin
                        state_d = PERSIST_ACTIVE;
                        event_d = 1'b1;
                    end else begin
                        state_d = PERSIST_COUNT;
                    end
                end
            end
            PERSIST_COUNT: begin
                if (!any_above_w) begin
                    state_d = PERSIST_IDLE;
                    units_d = 8'h00;
                end else if (tick_w) begin
                    units_d = units_q + 8'h01;
                    if (units_q + 8'h01 >= motion_persist_count_q) begin
                        state_d = PERSIST_ACTIVE;
                        event_d = 1'b1;
                    end
                end
            end
            PERSIST_ACTIVE: begin
                units_d = 8'h00;
                if (!any_above_w) begin
                    state_d = PERSIST_IDLE;
                end
            end
            default: begin
                state_d = PERSIST_IDLE;
                units_d = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            state_q <= PERSIST_IDLE;
            units_q <= 8'h00;
            event_q <= 1'b0;
            ref_taken_q <= 1'b0;
            valid_q <= 1'b0;
        end else if (ce_in) begin
            state_q <= state_d;
            units_q <= units_d;
            event_q <= event_d;
            ref_taken_q <= motion_reference_select_q
                && (ref_taken_q || sample_valid_in);
            valid_q <= sample_valid_in;
        end
    end

    assign activity_event_out = event_q;
    assign activity_active_out = (state_q == PERSIST_ACTIVE);
    assign trimmed_valid_out = valid_q;

endmodule : accel_offset_activity_detect
`default_nettype wire

//--- accel_activity_monitor.sv
// checker for the trim and activity detection block, bound below
`timescale 1ns/100ps
`default_nettype none
module accel_activity_monitor
    import motion_pkg::*;
#(
    parameter int FAST_CYCLES = UNIT_FAST_CYCLES,
    parameter int SLOW_CYCLES = UNIT_SLOW_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic sample_valid_in,
    input wire logic [SAMPLE_WIDTH-1:0] x_trimmed_out,
    input wire logic trimmed_valid_out,
    input wire logic activity_event_out,
    input wire logic activity_active_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);
    wire logic rd_take = ce_in && reg_read_in;

    valid_follow_a: assert property (
        ce_in |=> trimmed_valid_out == $past(sample_valid_in))
        else $error("trimmed valid does not follow sample valid");
    trim_hold_a: assert property (
        ce_in && !sample_valid_in |=> $stable(x_trimmed_out))
        else $error("trimmed x changed without a sample");
    trim_reserved_a: assert property (
        rd_take && reg_addr_in inside {[8'h20:8'h22]}
        |=> reg_rdata_out[7:4] == 4'h0)
        else $error("trim upper nibble not zero");
    low_reserved_a: assert property (
        rd_take && reg_addr_in inside {8'h26, 8'h28}
        |=> reg_rdata_out[4:1] == 4'h0)
        else $error("low limit reserved bits not zero");
    x_low_reserved_a: assert property (
        rd_take && reg_addr_in == X_MOTION_LIMIT_LOW_ADDR
        |=> reg_rdata_out[4:2] == 3'h0)
        else $error("x low limit reserved bits not zero");
    unmapped_zero_a: assert property (
        rd_take && !(reg_addr_in inside {[8'h20:8'h29]})
        |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    event_pulse_a: assert property (
        activity_event_out && ce_in |=> !activity_event_out)
        else $error("activity event longer than one cycle");
    event_active_a: assert property (
        activity_event_out |-> activity_active_out)
        else $error("event without active level");
    active_rise_a: assert property (
        $rose(activity_active_out) |-> activity_event_out)
        else $error("active rose without event");
    event_rearm_a: assert property (
        activity_event_out |-> $past(activity_active_out) == 1'b0)
        else $error("event while already active");
endmodule : accel_activity_monitor

bind accel_offset_activity_detect accel_activity_monitor #(
    .FAST_CYCLES(FAST_CYCLES),
    .SLOW_CYCLES(SLOW_CYCLES)
) mon (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .reg_addr_in(reg_addr_in),
    .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out),
    .sample_valid_in(sample_valid_in),
    .x_trimmed_out(x_trimmed_out),
    .trimmed_valid_out(trimmed_valid_out),
    .activity_event_out(activity_event_out),
    .activity_active_out(activity_active_out)
);
`default_nettype wire

//--- accel_host_model.sv
// host model on the parallel side of the serial register port
`timescale 1ns/100ps
`default_nettype none
module accel_host_model (
    input wire logic clk_sys_in,
    input wire logic [7:0] rdata_in,
    output logic [7:0] addr_out,
    output logic write_out,
    output logic [7:0] wdata_out,
    output logic read_out
);
    initial begin
        addr_out = 8'h00;
        write_out = 1'b0;
        wdata_out = 8'h00;
        read_out = 1'b0;
    end

    // released lines show the inverse so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        addr_out = a;
        wdata_out = d;
        write_out = 1'b1;
        @(negedge clk_sys_in);
        write_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_in);
        addr_out = a;
        read_out = 1'b1;
        @(negedge clk_sys_in);
        read_out = 1'b0;
        addr_out = ~a;
        d = rdata_in;
    endtask : rd
endmodule : accel_host_model
`default_nettype wire

//--- accel_offset_activity_detect_tb.sv
// self-checking testbench for trim and activity detection
`timescale 1ns/100ps
`default_nettype none
module accel_offset_activity_detect_tb;
    import motion_pkg::*;
    // short timer units keep the run brief
    localparam int FAST = 20;
    localparam int SLOW = 40;
    logic clk_sys_in, reset_in, ce_in, reg_write, reg_read, s_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] rate;
    logic [11:0] xs, ys, zs, xt, yt, zt;
    logic t_valid, evt, act;
    int bad_count, n_compared;

    accel_offset_activity_detect #(
        .FAST_CYCLES(FAST),
        .SLOW_CYCLES(SLOW)
    ) dut (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .reg_addr_in(reg_addr),
        .reg_write_in(reg_write),
        .reg_wdata_in(reg_wdata),
        .reg_read_in(reg_read),
        .reg_rdata_out(reg_rdata),
        .output_sample_rate_in(rate),
        .sample_valid_in(s_valid),
        .x_sample_in(xs),
        .y_sample_in(ys),
        .z_sample_in(zs),
        .x_trimmed_out(xt),
        .y_trimmed_out(yt),
        .z_trimmed_out(zt),
        .trimmed_valid_out(t_valid),
        .activity_event_out(evt),
        .activity_active_out(act)
    );

    accel_host_model host (
        .clk_sys_in(clk_sys_in),
        .rdata_in(reg_rdata),
        .addr_out(reg_addr),
        .write_out(reg_write),
        .wdata_out(reg_wdata),
        .read_out(reg_read)
    );

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic conclude;
        if (bad_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [11:0] e,
                       input logic [11:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic send(input logic [11:0] x, input logic [11:0] y,
                        input logic [11:0] z);
        @(negedge clk_sys_in);
        xs = x;
        ys = y;
        zs = z;
        s_valid = 1'b1;
        @(negedge clk_sys_in);
        s_valid = 1'b0;
        xs = ~x;
        ys = ~y;
        zs = ~z;
    endtask : send

    task automatic wait_evt(input int lim, output int n);
        n = 0;
        while (evt !== 1'b1) begin
            @(negedge clk_sys_in);
            n++;
            if (n > lim) begin
                bad_count++;
                conclude();
            end
        end
    endtask : wait_evt

    task automatic quiet(input int k, input string what);
        logic seen;
        seen = 1'b0;
        repeat (k) begin
            @(negedge clk_sys_in);
            seen = seen | evt;
        end
        chk(what, 12'h000, {11'h0, seen});
    endtask : quiet

    function automatic logic [7:0] mask(input logic [7:0] a);
        case (a)
            8'h20, 8'h21, 8'h22: return 8'h0f;
            8'h24: return 8'he3;
            8'h26, 8'h28: return 8'he1;
            8'h1f, 8'h2a: return 8'h00;
            default: return 8'hff;
        endcase
    endfunction : mask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        logic [7:0] d;
        for (logic [8:0] a = 9'h01f; a <= 9'h02a; a++) begin
            host.rd(a[7:0], d);
            chk("reset value", 12'h000, {4'h0, d});
            host.wr(a[7:0], 8'hff);
            host.rd(a[7:0], d);
            chk("reg mask", {4'h0, mask(a[7:0])}, {4'h0, d});
            host.wr(a[7:0], 8'h00);
        end
    endtask : t_regs

    task automatic t_trim;
        host.wr(X_OFFSET_TRIM_ADDR, 8'h07);
        host.wr(Y_OFFSET_TRIM_ADDR, 8'h08);
        host.wr(Z_OFFSET_TRIM_ADDR, 8'h07);
        send(12'h100, 12'h005, 12'h7fe);
        chk("trim valid", 12'h001, {11'h0, t_valid});
        chk("x trim", 12'h107, xt);
        chk("y trim", 12'hffd, yt);
        chk("z trim sat", 12'h7ff, zt);
        send(12'h800, 12'h800, 12'h7f9);
        chk("x trim neg", 12'h807, xt);
        chk("y trim sat", 12'h800, yt);
        chk("z trim sat", 12'h7ff, zt);
        ce_in = 1'b0;
        send(12'h001, 12'h001, 12'h001);
        ce_in = 1'b1;
        chk("x frozen", 12'h807, xt);
        host.wr(X_OFFSET_TRIM_ADDR, 8'h00);
        host.wr(Y_OFFSET_TRIM_ADDR, 8'h00);
        host.wr(Z_OFFSET_TRIM_ADDR, 8'h00);
    endtask : t_trim

    task automatic t_limit;
        int n;
        host.wr(X_MOTION_LIMIT_HIGH_ADDR, 8'h01);
        host.wr(X_MOTION_LIMIT_LOW_ADDR, 8'h21);
        send(12'h009, 12'h7ff, 12'h000);
        quiet(6, "equal or ignored");
        send(12'hff6, 12'h000, 12'h000);
        wait_evt(3, n);
        chk("count zero delay", 12'h001, {11'h0, n <= 2});
        chk("active", 12'h001, {11'h0, act});
        send(12'h000, 12'h000, 12'h000);
        @(negedge clk_sys_in);
        chk("active cleared", 12'h000, {11'h0, act});
    endtask : t_limit

    task automatic t_persist;
        int n;
        host.wr(MOTION_PERSIST_TIME_ADDR, 8'h03);
        send(12'h00a, 12'h000, 12'h000);
        wait_evt(200, n);
        chk("fast unit", 12'h001, {11'h0, n >= 3*FAST-2 && n <= 3*FAST+4});
        send(12'h000, 12'h000, 12'h000);
        rate = 3'h2;
        send(12'h00a, 12'h000, 12'h000);
        wait_evt(400, n);
        chk("slow unit", 12'h001, {11'h0, n >= 3*SLOW-2 && n <= 3*SLOW+4});
        send(12'h000, 12'h000, 12'h000);
        rate = RATE_CODE_FAST;
        send(12'h00a, 12'h000, 12'h000);
        quiet(2*FAST, "brief motion");
        send(12'h000, 12'h000, 12'h000);
        send(12'h00a, 12'h000, 12'h000);
        wait_evt(200, n);
        chk("count restart", 12'h001, {11'h0, n >= 3*FAST-2});
        send(12'h000, 12'h000, 12'h000);
        host.wr(MOTION_PERSIST_TIME_ADDR, 8'h00);
    endtask : t_persist

    task automatic t_ref;
        int n;
        host.wr(X_MOTION_LIMIT_LOW_ADDR, 8'h23);
        send(12'h200, 12'h000, 12'h000);
        send(12'h205, 12'h000, 12'h000);
        quiet(4, "near reference");
        send(12'h210, 12'h000, 12'h000);
        wait_evt(3, n);
        chk("past reference", 12'h001, {11'h0, act});
        host.wr(X_MOTION_LIMIT_LOW_ADDR, 8'h00);
        send(12'h000, 12'h000, 12'h000);
    endtask : t_ref

    // ------------------------------------------------------------------
    // clock, reset and sequence
    // ------------------------------------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    initial begin
        reset_in = 1'b1;
        ce_in = 1'b1;
        rate = RATE_CODE_FAST;
        s_valid = 1'b0;
        xs = 12'h000;
        ys = 12'h000;
        zs = 12'h000;
        bad_count = 0;
        n_compared = 0;
        repeat (4) @(negedge clk_sys_in);
        reset_in = 1'b0;
        t_regs();
        t_trim();
        t_limit();
        t_persist();
        t_ref();
        conclude();
    end
endmodule : accel_offset_activity_detect_tb
`default_nettype wire
